// file: rtl/ssmt_pkg.sv
// Constants, modes and carrier types of the serial port.
package ssmt_pkg;

  localparam int BYTE_W = 8;
  localparam int EDGE_W = 4;
  localparam int DIV_W = 8;
  localparam int TX_DEPTH = 32;
  localparam int MSB_POS = 7;
  localparam int SEL_OUT_BIT = 1;
  localparam int SEL_LVL_BIT = 0;
  localparam logic [EDGE_W-1:0] LAST_EDGE = 4'hF;
  localparam logic [EDGE_W-1:0] EDGE_RST = 4'h0;
  localparam logic [EDGE_W-1:0] EDGE_ONE = 4'h1;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [1:0] SEL_3WIRE = 2'h0;
  localparam logic [1:0] SEL_4WIRE_IN = 2'h1;

  typedef enum logic
  {
    MST_IDLE = 1'b0,
    MST_XFER = 1'b1
  } ssmt_mst_e;

  typedef struct packed
  {
    logic              port_enable;
    logic              master_role_enable;
    logic [1:0]        select_mode_field;
    logic              clock_phase_select;
    logic              clock_polarity_select;
    logic [DIV_W-1:0]  rate_div;
  } ssmt_cfg_s;

  typedef struct packed
  {
    logic mosi;
    logic miso;
    logic sck;
    logic nss;
  } ssmt_pin_in_s;

  typedef struct packed
  {
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic sck_o;
    logic sck_oe;
    logic nss_o;
    logic nss_oe;
    logic nss_routed;
  } ssmt_pin_out_s;

  localparam ssmt_pin_out_s PINS_RST = '0;

  typedef struct packed
  {
    ssmt_mst_e           mst;
    logic [DIV_W-1:0]    div_cnt;
    logic [EDGE_W-1:0]   edge_cnt;
    logic [BYTE_W-1:0]   shreg;
    logic                slv_loaded;
    logic                sck_prev;
    logic                nss_prev;
    logic [BYTE_W-1:0]   rx_buf;
    logic                done_flag;
    logic                mode_fault;
    ssmt_pin_out_s       pins;
  } ssmt_state_s;

endpackage : ssmt_pkg

// file: rtl/ssmt_core.sv
// Transmit FIFO and the serial port engine for master and slave roles.
`timescale 1ns/100ps
`default_nettype none

module ssmt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  // Filling side.
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  // Draining side.
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed
  {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic          ready;
  } ssmt_fifo_state_s;

  ssmt_fifo_state_s r_reg;
  ssmt_fifo_state_s r_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign out_valid = (r_reg.count != '0);
  assign out_data  = mem[r_reg.rd_ptr];
  assign in_ready  = r_reg.ready;
  assign push      = in_valid & r_reg.ready;
  assign pop       = out_ready & out_valid;

  always_comb
  begin
    r_next = r_reg;
    if (push)
    begin
      r_next.wr_ptr = (r_reg.wr_ptr == PTR_LAST) ? '0 : r_reg.wr_ptr + AW'(1);
    end
    if (pop)
    begin
      r_next.rd_ptr = (r_reg.rd_ptr == PTR_LAST) ? '0 : r_reg.rd_ptr + AW'(1);
    end
    if (push & !pop)
    begin
      r_next.count = r_reg.count + CW'(1);
    end
    else if (pop & !push)
    begin
      r_next.count = r_reg.count - CW'(1);
    end
    r_next.ready = (r_next.count != CNT_FULL);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      r_reg <= '{wr_ptr: '0, rd_ptr: '0, count: '0, ready: 1'b1};
    end
    else if (ce)
    begin
      r_reg <= r_next;
      if (push)
      begin
        mem[r_reg.wr_ptr] <= in_data;
      end
    end
  end

endmodule : ssmt_fifo

// How it works
// - Master-out is our output as master, our input as slave, MSB first.
// - Master-in is our input as master, our output as slave, MSB first.
// - Master-in floats when disabled or as an unselected four-wire slave.
// - Three-wire slave drives master-in from the shift register all the time.
// - Serial clock is driven as master and taken as input as slave.
// - Unselected four-wire slave ignores every serial clock edge.
// - Mode 00 is three-wire, select unused, slave always selected.
// - Mode 01 is four-wire with select input; low select enables the slave.
// - Mode 01 master drops its master role on a falling select.
// - Mode 1x drives select as output at the level of the low bit.
// - Select is unrouted in three-wire mode 00 and routed in modes 01 and 1x.
// - Master role is taken when the master enable bit is one.
// - Writes fill the transmit buffer; an empty shifter loads and starts at once.
// - Master drives the clock and shifts out and in together, MSB first.
// - A finished transfer copies the shifter into the receive buffer.
// - A waiting transmit byte loads and starts the next transfer without pause.
// - An empty transmit buffer at byte end stops the clock until new data.
// - Reading the data window returns the receive buffer.
// - Clock stays at most core clock over 2 as master, over 10 as slave.
// - Master clock comes from an 8-bit rate divider of the core clock.
// - All four clock phase and polarity combinations are supported.
// - Phase picks the latching edge, polarity the idle level; both ends match.
// - The done flag is set by hardware at the end of every byte.
// - A slave copies the byte to the receive buffer after 8 bits.
// - A four-wire slave clears its bit counter on each falling select.
module ssmt_core
  import ssmt_pkg::*;
#(
  parameter int TX_WORDS = TX_DEPTH
) (
  // Clock, reset and clock enable.
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Configuration.
  input  wire ssmt_cfg_s         cfg,
  // Data window write side.
  input  wire logic              wr_valid,
  input  wire logic [BYTE_W-1:0] wr_data,
  output var  logic              wr_ready,
  // Data window read side and flags.
  output var  logic [BYTE_W-1:0] rd_data,
  output var  logic              transfer_done_flag,
  input  wire logic              done_clear,
  output var  logic              mode_fault,
  input  wire logic              fault_clear,
  // Bus pins.
  input  wire ssmt_pin_in_s      pin_i,
  output var  ssmt_pin_out_s     pin_o
);

  ssmt_state_s       r_reg;
  ssmt_state_s       r_next;
  logic              tx_valid;
  logic [BYTE_W-1:0] tx_data;
  logic              tx_pop;
  logic              fifo_in_ready;
  logic              master_act;
  logic              slave_act;
  logic              four_in;
  logic              selected;
  logic              nss_fall;
  logic              m_tick;
  logic              ev_lead;
  logic              ev_trail;
  logic              ev_sample;
  logic              ev_drive;
  logic              byte_end;
  logic              in_bit;
  logic [BYTE_W-1:0] shifted;

  // A write is taken only while the clock enable lets the FIFO move.
  ssmt_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (TX_WORDS)
  ) u_tx_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (fifo_in_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_pop)
  );

  assign wr_ready           = fifo_in_ready;
  assign rd_data            = r_reg.rx_buf;
  assign transfer_done_flag = r_reg.done_flag;
  assign mode_fault         = r_reg.mode_fault;
  assign pin_o              = r_reg.pins;

  // Role and selection.
  assign master_act = cfg.port_enable & cfg.master_role_enable & !r_reg.mode_fault;
  assign slave_act  = cfg.port_enable & !master_act;
  assign four_in    = (cfg.select_mode_field == SEL_4WIRE_IN);
  assign selected   = !four_in | !pin_i.nss;
  assign nss_fall   = r_reg.nss_prev & !pin_i.nss;

  // Master edges come from the divider, slave edges from the clock pin.
  assign m_tick = (r_reg.mst == MST_XFER) & (r_reg.div_cnt == cfg.rate_div);
  always_comb
  begin
    ev_lead  = 1'b0;
    ev_trail = 1'b0;
    if (master_act)
    begin
      ev_lead  = m_tick & !r_reg.edge_cnt[0];
      ev_trail = m_tick & r_reg.edge_cnt[0];
    end
    else if (slave_act & selected)
    begin
      ev_lead  = (pin_i.sck ^ cfg.clock_polarity_select) & !(r_reg.sck_prev ^ cfg.clock_polarity_select);
      ev_trail = !(pin_i.sck ^ cfg.clock_polarity_select) & (r_reg.sck_prev ^ cfg.clock_polarity_select);
    end
  end

  assign ev_sample = cfg.clock_phase_select ? ev_trail : ev_lead;
  assign ev_drive  = cfg.clock_phase_select ? ev_lead : ev_trail;
  assign byte_end  = ev_trail & (r_reg.edge_cnt == LAST_EDGE);
  assign in_bit    = master_act ? pin_i.miso : pin_i.mosi;
  assign shifted   = {r_reg.shreg[BYTE_W-2:0], in_bit};

  always_comb
  begin
    r_next          = r_reg;
    tx_pop          = 1'b0;
    r_next.sck_prev = pin_i.sck;
    r_next.nss_prev = pin_i.nss;

    // Shifting common to both roles, most significant bit first.
    if (ev_sample)
    begin
      r_next.shreg = shifted;
    end
    if (ev_drive & master_act)
    begin
      r_next.pins.mosi_o = r_reg.shreg[MSB_POS];
    end
    if (ev_drive & slave_act)
    begin
      r_next.pins.miso_o = r_reg.shreg[MSB_POS];
    end
    if (ev_lead | ev_trail)
    begin
      r_next.edge_cnt = r_reg.edge_cnt + EDGE_ONE;
    end
    if (byte_end)
    begin
      r_next.rx_buf = cfg.clock_phase_select ? shifted : r_reg.shreg;
    end

    // Master sequencing.
    if (master_act)
    begin
      unique case (r_reg.mst)
        MST_IDLE:
        begin
          r_next.pins.sck_o = cfg.clock_polarity_select;
          if (tx_valid)
          begin
            tx_pop          = 1'b1;
            r_next.shreg    = tx_data;
            r_next.mst      = MST_XFER;
            r_next.div_cnt  = DIV_RST;
            r_next.edge_cnt = EDGE_RST;
            if (!cfg.clock_phase_select)
            begin
              r_next.pins.mosi_o = tx_data[MSB_POS];
            end
          end
        end
        MST_XFER:
        begin
          r_next.div_cnt = m_tick ? DIV_RST : r_reg.div_cnt + DIV_ONE;
          if (m_tick)
          begin
            r_next.pins.sck_o = ~r_reg.pins.sck_o;
          end
          if (byte_end)
          begin
            if (tx_valid)
            begin
              tx_pop          = 1'b1;
              r_next.shreg    = tx_data;
              r_next.edge_cnt = EDGE_RST;
              if (!cfg.clock_phase_select)
              begin
                r_next.pins.mosi_o = tx_data[MSB_POS];
              end
            end
            else
            begin
              r_next.mst = MST_IDLE;
            end
          end
        end
      endcase
    end
    else
    begin
      r_next.mst     = MST_IDLE;
      r_next.div_cnt = DIV_RST;
    end

    // Slave loading at byte boundaries.
    if (slave_act)
    begin
      if (four_in & nss_fall)
      begin
        r_next.edge_cnt = EDGE_RST;
      end
      else if (!r_reg.slv_loaded & tx_valid & (r_reg.edge_cnt == EDGE_RST) & !ev_lead & !ev_trail)
      begin
        tx_pop            = 1'b1;
        r_next.shreg      = tx_data;
        r_next.slv_loaded = 1'b1;
        if (!cfg.clock_phase_select)
        begin
          r_next.pins.miso_o = tx_data[MSB_POS];
        end
      end
      if (byte_end)
      begin
        r_next.slv_loaded = 1'b0;
      end
    end

    // A disabled port forgets any partial byte.
    if (!cfg.port_enable)
    begin
      r_next.edge_cnt   = EDGE_RST;
      r_next.slv_loaded = 1'b0;
    end

    // Flags: a set in the same cycle as a clear wins.
    if (done_clear)
    begin
      r_next.done_flag = 1'b0;
    end
    if (byte_end)
    begin
      r_next.done_flag = 1'b1;
    end
    if (fault_clear)
    begin
      r_next.mode_fault = 1'b0;
    end
    if (cfg.port_enable & cfg.master_role_enable & four_in & nss_fall)
    begin
      r_next.mode_fault = 1'b1;
      r_next.mst        = MST_IDLE;
    end

    // Pin directions and select output.
    r_next.pins.mosi_oe    = master_act;
    r_next.pins.sck_oe     = master_act;
    r_next.pins.miso_oe    = slave_act & selected;
    r_next.pins.nss_oe     = cfg.port_enable & cfg.select_mode_field[SEL_OUT_BIT];
    r_next.pins.nss_o      = cfg.select_mode_field[SEL_LVL_BIT];
    r_next.pins.nss_routed = (cfg.select_mode_field != SEL_3WIRE);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      r_reg <= '{mst: MST_IDLE, div_cnt: DIV_RST, edge_cnt: EDGE_RST, shreg: BYTE_RST,
                 slv_loaded: 1'b0, sck_prev: pin_i.sck, nss_prev: 1'b1, rx_buf: BYTE_RST,
                 done_flag: 1'b0, mode_fault: 1'b0, pins: PINS_RST};
    end
    else if (ce)
    begin
      r_reg <= r_next;
    end
  end

endmodule : ssmt_core

`default_nettype wire

// file: sim/ssmt_core_asserts.sv
// Concurrent checks on the ports of the serial port core.
`timescale 1ns/100ps
`default_nettype none

module ssmt_core_asserts
  import ssmt_pkg::*;
(
  // Clock and reset.
  input wire logic          clk,
  input wire logic          nrst,
  input wire logic          ce,
  // Settings and flags.
  input wire ssmt_cfg_s     cfg,
  input wire logic          transfer_done_flag,
  input wire logic          mode_fault,
  // Pins.
  input wire ssmt_pin_in_s  pin_i,
  input wire ssmt_pin_out_s pin_o
);
  logic [3:0] tog_reg;
  logic [7:0] gap_reg;
  wire logic  sl = ce && cfg.port_enable && !cfg.master_role_enable;
  wire logic  ms = ce && cfg.port_enable && cfg.master_role_enable;

  // Counts clock toggles and the cycles between them while the clock is driven.
  always_ff @(posedge clk)
  begin
    if (!nrst || !pin_o.sck_oe)
    begin
      tog_reg <= 4'h0;
      gap_reg <= 8'h00;
    end
    else if ($past(pin_o.sck_oe) && $changed(pin_o.sck_o))
    begin
      tog_reg <= tog_reg + 4'h1;
      gap_reg <= 8'h00;
    end
    else if (gap_reg != 8'hFF)
      gap_reg <= gap_reg + 8'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_miso_off: assert property (ce && !cfg.port_enable |=> !pin_o.miso_oe)
    else $error("master-in driven while disabled");
  a_miso_sel: assert property (sl && cfg.select_mode_field == SEL_4WIRE_IN |=> pin_o.miso_oe == !$past(pin_i.nss))
    else $error("master-in drive does not follow select");
  a_miso_3wire: assert property (sl && cfg.select_mode_field == SEL_3WIRE |=> pin_o.miso_oe)
    else $error("three-wire slave not driving master-in");
  a_master_pins: assert property (ms && !mode_fault ##1 !mode_fault |-> pin_o.sck_oe && pin_o.mosi_oe && !pin_o.miso_oe)
    else $error("master pin directions wrong");
  a_slave_pins: assert property (sl |=> !pin_o.sck_oe && !pin_o.mosi_oe)
    else $error("slave drives clock or master-out");
  a_sel_route: assert property (ce |=> pin_o.nss_routed == ($past(cfg.select_mode_field) != SEL_3WIRE))
    else $error("select routing wrong");
  a_sel_drive: assert property (ce && cfg.select_mode_field[SEL_OUT_BIT] |=> pin_o.nss_oe == $past(cfg.port_enable)
    && pin_o.nss_o == $past(cfg.select_mode_field[SEL_LVL_BIT]))
    else $error("select output wrong");
  a_mm_drop: assert property (ms && cfg.select_mode_field == SEL_4WIRE_IN && $fell(pin_i.nss) |=> mode_fault ##1 !pin_o.sck_oe)
    else $error("master role kept after falling select");
  a_unsel_quiet: assert property (sl && cfg.select_mode_field == SEL_4WIRE_IN && pin_i.nss |=> !$rose(transfer_done_flag))
    else $error("unselected slave finished a byte");
  a_byte_edges: assert property ($rose(transfer_done_flag) && pin_o.sck_oe |-> tog_reg == 4'hF && $changed(pin_o.sck_o))
    else $error("byte end not on the sixteenth clock toggle");
  a_sck_rate: assert property (pin_o.sck_oe && $past(pin_o.sck_oe) && $changed(pin_o.sck_o) |-> gap_reg >= cfg.rate_div)
    else $error("serial clock faster than the divider allows");

  c_master_byte: cover property ($rose(transfer_done_flag) && pin_o.sck_oe);
  c_slave_byte: cover property ($rose(transfer_done_flag) && !pin_o.sck_oe);
  c_fault: cover property ($rose(mode_fault));

endmodule : ssmt_core_asserts

bind ssmt_core ssmt_core_asserts ssmt_core_asserts_i (.clk(clk), .nrst(nrst), .ce(ce), .cfg(cfg),
  .transfer_done_flag(transfer_done_flag), .mode_fault(mode_fault), .pin_i(pin_i), .pin_o(pin_o));

`default_nettype wire

// file: sim/ssmt_slave_model.sv
// Behavioural serial slave, the only one on the bus, that answers the master.
`timescale 1ns/100ps
`default_nettype none

module ssmt_slave_model
  import ssmt_pkg::*;
(
  // Bus and settings.
  input  wire logic              sck,
  input  wire logic              mosi,
  input  wire logic              cpol,
  input  wire logic              cpha,
  input  wire logic              rst,
  input  wire logic [BYTE_W-1:0] tx,
  // Results.
  output var  logic              miso,
  output var  logic [BYTE_W-1:0] rx,
  output var  int                n
);
  logic [BYTE_W-1:0] sh;
  int                e;

  initial n = 0;

  // Samples on the latching edge and shifts on the other, MSB first.
  always @(posedge rst or posedge sck or negedge sck)
  begin
    if (rst)
    begin
      e = 0;
      sh = tx;
      miso = tx[MSB_POS];
    end
    else
    begin
      e = e + 1;
      if ((sck != cpol) != cpha)
        rx = {rx[BYTE_W-2:0], mosi};
      else if (cpha)
      begin
        miso = sh[MSB_POS];
        sh = sh << 1;
      end
      else
      begin
        sh = sh << 1;
        miso = sh[MSB_POS];
      end
      if (e == 16)
      begin
        e = 0;
        n = n + 1;
        sh = tx;
        miso = tx[MSB_POS];
      end
    end
  end

endmodule : ssmt_slave_model

`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the serial port core.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import ssmt_pkg::*;
  logic          clk = 1'b0;
  logic          nrst = 1'b0;
  logic          wr_valid = 1'b0;
  logic          done_clear = 1'b0;
  logic          fault_clear = 1'b0;
  logic          ce = 1'b1;
  logic          t_sck = 1'b0;
  logic          t_mosi = 1'b0;
  logic          t_nss = 1'b1;
  logic          s_rst = 1'b0;
  logic [7:0]    wr_data = 8'h00;
  logic [7:0]    s_tx = 8'h5A;
  logic [7:0]    s_got = 8'h00;
  ssmt_cfg_s     cfg = '0;
  logic          wr_ready;
  logic          done;
  logic          mode_fault;
  logic          s_miso;
  logic [7:0]    rd_data;
  logic [7:0]    s_rx;
  int            s_n;
  int            mismatches = 0;
  int            n_tests = 0;
  ssmt_pin_in_s  pin_i;
  ssmt_pin_out_s pin_o;

  assign pin_i = {pin_o.mosi_oe ? pin_o.mosi_o : t_mosi, pin_o.miso_oe ? pin_o.miso_o : s_miso,
                  pin_o.sck_oe ? pin_o.sck_o : t_sck, pin_o.nss_oe ? pin_o.nss_o : t_nss};

  ssmt_core ssmt_core_i (.clk(clk), .nrst(nrst), .ce(ce), .cfg(cfg), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_data(rd_data), .transfer_done_flag(done), .done_clear(done_clear),
    .mode_fault(mode_fault), .fault_clear(fault_clear), .pin_i(pin_i), .pin_o(pin_o));
  ssmt_slave_model ssmt_slave_model_i (.sck(pin_i.sck), .mosi(pin_i.mosi), .cpol(cfg.clock_polarity_select),
    .cpha(cfg.clock_phase_select), .rst(s_rst), .tx(s_tx), .miso(s_miso), .rx(s_rx), .n(s_n));

  always #5 clk = ~clk;

  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic hang();
    mismatches++;
    $display("Error %0t: wait timed out", $time);
    stop_test();
  endtask : hang

  task automatic clr();
    done_clear = 1'b1;
    fault_clear = 1'b1;
    cyc(1);
    done_clear = 1'b0;
    fault_clear = 1'b0;
    cyc(1);
  endtask : clr

  task automatic setc(input logic ms, input logic [1:0] md, input logic ph, input logic po, input logic [7:0] dv);
    cfg.port_enable = 1'b0;
    cyc(2);
    cfg = '{1'b0, ms, md, ph, po, dv};
    t_sck = po;
    cyc(2);
    cfg.port_enable = 1'b1;
    cyc(3);
    s_rst = 1'b1;
    cyc(1);
    s_rst = 1'b0;
    clr();
  endtask : setc

  task automatic wr(input logic [7:0] b);
    logic ok;
    ok = 1'b0;
    wr_valid = 1'b1;
    wr_data = b;
    for (int i = 0; i < 900 && !ok; i++)
    begin
      @(posedge clk);
      ok = wr_ready;
      @(negedge clk);
    end
    wr_valid = 1'b0;
    if (!ok)
      hang();
  endtask : wr

  task automatic wt(input int nb);
    for (int i = 0; i < 9000 && s_n < nb; i++)
      cyc(1);
    if (s_n < nb)
      hang();
    cyc(2);
  endtask : wt

  task automatic sk(input int k);
    repeat (k)
    begin
      cyc(6);
      if (t_sck == cfg.clock_polarity_select)
        s_got = {s_got[6:0], pin_o.miso_o};
      t_sck = ~t_sck;
    end
    cyc(3);
  endtask : sk

  initial
  begin
    int b;
    int k;
    cyc(16);
    cmp1(pin_o == PINS_RST, 1'b1);
    cmp1(wr_ready, 1'b1);
    cmp8(rd_data, BYTE_RST);
    nrst = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      s_tx = 8'h3C + m[7:0];
      setc(1'b1, SEL_3WIRE, m[1], m[0], 8'h01);
      b = s_n;
      wr(8'hA5 ^ m[7:0]);
      wt(b + 1);
      cmp8(rd_data, 8'h3C + m[7:0]);
      cmp8(s_rx, 8'hA5 ^ m[7:0]);
      cmp1(done, 1'b1);
      cmp1(pin_o.nss_routed, 1'b0);
    end
    for (int m = 2; m < 4; m++)
    begin
      setc(1'b1, m[1:0], 1'b0, 1'b0, 8'h01);
      cmp1(pin_o.nss_oe, 1'b1);
      cmp1(pin_o.nss_o, m[0]);
      cmp1(pin_o.nss_routed, 1'b1);
    end
    setc(1'b1, SEL_4WIRE_IN, 1'b0, 1'b0, 8'h07);
    wr(8'h81);
    cyc(40);
    t_nss = 1'b0;
    cyc(3);
    cmp1(mode_fault, 1'b1);
    cmp1(pin_o.sck_oe, 1'b0);
    t_nss = 1'b1;
    clr();
    cmp1(mode_fault, 1'b0);
    s_tx = 8'h96;
    setc(1'b1, SEL_3WIRE, 1'b0, 1'b0, 8'h03);
    b = s_n;
    k = 0;
    wr_valid = 1'b1;
    repeat (40)
    begin
      @(posedge clk);
      if (wr_ready)
        k++;
      @(negedge clk);
      wr_data = k[7:0];
    end
    wr_valid = 1'b0;
    cmp8(k[7:0], 8'h21);
    wt(b + 33);
    cmp8(s_rx, 8'h20);
    cmp8(rd_data, 8'h96);
    cyc(100);
    cmp8(s_n[7:0], b[7:0] + 8'h21);
    cmp1(pin_o.sck_o, 1'b0);
    setc(1'b0, SEL_4WIRE_IN, 1'b0, 1'b0, 8'h00);
    t_mosi = 1'b1;
    cmp1(pin_o.miso_oe, 1'b0);
    sk(16);
    cmp1(done, 1'b0);
    t_nss = 1'b0;
    cyc(3);
    cmp1(pin_o.miso_oe, 1'b1);
    sk(6);
    t_nss = 1'b1;
    cyc(3);
    t_nss = 1'b0;
    sk(10);
    cmp1(done, 1'b0);
    sk(6);
    cmp1(done, 1'b1);
    cmp8(rd_data, 8'hFF);
    t_nss = 1'b1;
    setc(1'b0, SEL_3WIRE, 1'b0, 1'b0, 8'h00);
    cmp1(pin_o.miso_oe, 1'b1);
    wr(8'hC3);
    sk(16);
    cmp1(done, 1'b1);
    cmp8(s_got, 8'hC3);
    ce = 1'b0;
    clr();
    cmp1(done, 1'b1);
    ce = 1'b1;
    cfg.port_enable = 1'b0;
    cyc(2);
    cmp1(pin_o.miso_oe, 1'b0);
    stop_test();
  end

endmodule : tb

`default_nettype wire
